// ==== design/irq_arb_pkg.sv ====
// Constants shared by the interrupt arbiter and break source.
// Assumes a byte-wide register port and a 16-bit CPU address space.
package irq_arb_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_STATUS_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h01;
  localparam logic [7:0] OFS_STATUS_THREE = 8'h02;
  localparam logic [7:0] OFS_BRK_ADDR_HI = 8'h03;
  localparam logic [7:0] OFS_BRK_ADDR_LO = 8'h04;
  localparam logic [7:0] OFS_BRK_CTRL = 8'h05;
  localparam logic [7:0] OFS_ARB_STATE = 8'h06;
  // Break control fields
  localparam int BRK_EN_BIT = 7;
  localparam int BRK_REQ_BIT = 6;
  localparam int BRK_ACT_BIT = 5;
  // Position of the mask bit inside the condition code byte
  localparam int CCR_I_BIT = 3;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] BRK_ADDR_RESET = 16'h0000;
  // Vectors
  localparam logic [15:0] VEC_SWI_NORMAL = 16'hFFFC;
  localparam logic [15:0] VEC_SWI_MONITOR = 16'hFEFC;
  localparam logic [15:0] VEC_HW_TOP = 16'hFFFA;
  // Sequence step numbers
  localparam logic [3:0] ENT_VEC_HI = 4'h6;
  localparam logic [3:0] ENT_VEC_LO = 4'h7;
  localparam logic [3:0] ENT_START = 4'h8;
  localparam logic [3:0] REC_OPCODE = 4'h5;
  localparam logic [3:0] REC_OPERAND = 4'h6;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_RECOVER} seq_state_t;
endpackage

// ==== design/interrupt_arbiter_break_source.sv ====
// Interrupt latch, arbiter, entry/return bus sequencer and break source.
// Assumes the CPU holds its register values and pointer stable while busy is high
// and that memory answers a read in the cycle its address is shown.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
// What this block does
// R01: Latch requests, arbitrate when processing starts
// R02: Arbitration yields a constant selecting the vector
// R03: Latched request held until serviced or unmasked
// R04: Entry pushes registers and sets mask
// R05: Return restores registers from stack
// R06: Requests checked only after instruction completes
// R07: Start only if unmasked and source enabled
// R08: Highest priority pending request served first
// R09: Pending request served right after return
// R10: High index register never pushed on entry
// R11: Entry bus: pointer, four lower, vectors, start
// R12: Return bus: pointer-4 up, then opcode, operand
// R13: Software interrupt ignores the mask
// R14: Status flags show requests, read-only, reset zero
// R15: First status: flags one-six, low bits zero
// R16: Second status: flags seven to fourteen
// R17: Third status: flags fifteen to twenty-two
// R18: Address match raises breakpoint, loads software interrupt
// R19: Writing request bit starts a break
// R20: Break vector normal or monitor pair
// R21: Return in break routine ends break
// R22: Status flags follow request lines every cycle
module interrupt_arbiter_break_source #(
  parameter int NUM_SRC = 22
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [NUM_SRC-1:0] src_en,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic cli_exec,
  input wire logic sei_exec,
  input wire logic monitor_mode,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_sp,
  input wire logic [7:0] cpu_a,
  input wire logic [7:0] cpu_x,
  input wire logic [7:0] cpu_ccr,
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_write,
  output logic bus_valid,
  output logic busy,
  output logic i_mask,
  output logic [15:0] vector_addr,
  output logic load_swi_op,
  output logic breakpoint_signal,
  output logic entry_done,
  output logic restore_done,
  output logic [15:0] restored_pc,
  output logic [7:0] restored_a,
  output logic [7:0] restored_x,
  output logic [7:0] restored_ccr
);
  irq_arb_pkg::seq_state_t state, next_state;
  logic [3:0] step, next_step;
  logic [21:0] status_flags;
  logic [4:0] latched_id, next_latched_id;
  logic latch_valid, next_latch_valid;
  logic next_i_mask;
  logic [15:0] base_sp, next_base_sp;
  logic [15:0] next_vector_addr;
  logic [7:0] vec_hi, next_vec_hi, vec_lo, next_vec_lo;
  logic [15:0] brk_addr, next_brk_addr;
  logic brk_en, next_brk_en;
  logic brk_pending, next_brk_pending;
  logic break_active, next_break_active;
  logic resume, next_resume;
  logic next_load_swi_op, next_breakpoint, next_entry_done, next_restore_done;
  logic [15:0] next_restored_pc;
  logic [7:0] next_restored_a, next_restored_x, next_restored_ccr;
  logic [15:0] next_bus_addr;
  logic [7:0] next_bus_wdata;
  logic next_bus_write, next_bus_valid;
  logic [7:0] next_reg_rdata;
  logic hw_any;
  logic [4:0] hw_id;
  logic addr_match;

  // Fixed priority: lowest source number wins among enabled requests
  always_comb
  begin
    hw_any = 1'b0;
    hw_id = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (src_req[i] && src_en[i]) // [R07] [R08]
      begin
        hw_any = 1'b1;
        hw_id = 5'(i);
      end
    end
  end

  // Break address comparator on the CPU address bus
  assign addr_match = brk_en && cpu_addr_valid && (cpu_addr == brk_addr); // [R18]

  // Sequencer, latch, break and register write next values
  always_comb
  begin
    next_state = state;
    next_step = step;
    next_latched_id = latched_id;
    next_latch_valid = latch_valid;
    next_i_mask = i_mask;
    next_base_sp = base_sp;
    next_vector_addr = vector_addr;
    next_vec_hi = vec_hi;
    next_vec_lo = vec_lo;
    next_brk_addr = brk_addr;
    next_brk_en = brk_en;
    next_brk_pending = brk_pending;
    next_break_active = break_active;
    next_resume = 1'b0;
    next_load_swi_op = 1'b0;
    next_breakpoint = 1'b0;
    next_entry_done = 1'b0;
    next_restore_done = 1'b0;
    next_restored_pc = restored_pc;
    next_restored_a = restored_a;
    next_restored_x = restored_x;
    next_restored_ccr = restored_ccr;
    if (cli_exec)
    begin
      next_i_mask = 1'b0;
      next_latch_valid = 1'b0; // [R03]
    end
    else if (sei_exec)
    begin
      next_i_mask = 1'b1;
    end
    unique case (state)
      irq_arb_pkg::ST_IDLE:
      begin
        if (instr_done || resume) // [R06] [R09]
        begin
          if (brk_pending)
          begin
            next_brk_pending = 1'b0;
            next_load_swi_op = 1'b1; // [R18]
            next_break_active = 1'b1;
            next_vector_addr = monitor_mode ? irq_arb_pkg::VEC_SWI_MONITOR
                                            : irq_arb_pkg::VEC_SWI_NORMAL; // [R20]
            next_state = irq_arb_pkg::ST_ENTRY;
          end
          else if (swi_exec && instr_done)
          begin
            next_vector_addr = monitor_mode ? irq_arb_pkg::VEC_SWI_MONITOR
                                            : irq_arb_pkg::VEC_SWI_NORMAL; // [R13]
            next_state = irq_arb_pkg::ST_ENTRY;
          end
          else if (hw_any && !i_mask) // [R07]
          begin
            next_latched_id = hw_id; // [R01] [R08]
            next_latch_valid = 1'b1;
            next_vector_addr = 16'(irq_arb_pkg::VEC_HW_TOP - {10'h000, hw_id, 1'b0}); // [R02]
            next_state = irq_arb_pkg::ST_ENTRY;
          end
          if (next_state == irq_arb_pkg::ST_ENTRY)
          begin
            next_i_mask = 1'b1; // [R04]
            next_base_sp = cpu_sp;
            next_step = 4'h0;
          end
        end
        else if (rti_exec)
        begin
          next_base_sp = cpu_sp;
          next_step = 4'h0;
          next_state = irq_arb_pkg::ST_RECOVER;
        end
      end
      irq_arb_pkg::ST_ENTRY:
      begin
        next_step = 4'(step + 4'h1);
        if (step == irq_arb_pkg::ENT_VEC_HI)
        begin
          next_vec_hi = bus_rdata;
        end
        if (step == irq_arb_pkg::ENT_VEC_LO)
        begin
          next_vec_lo = bus_rdata;
        end
        if (step == irq_arb_pkg::ENT_START)
        begin
          next_entry_done = 1'b1;
          next_latch_valid = 1'b0; // [R03]
          next_step = 4'h0;
          next_state = irq_arb_pkg::ST_IDLE;
        end
      end
      irq_arb_pkg::ST_RECOVER:
      begin
        next_step = 4'(step + 4'h1);
        unique case (step)
          4'h0: next_restored_ccr = bus_rdata; // [R05]
          4'h1: next_restored_a = bus_rdata;
          4'h2: next_restored_x = bus_rdata;
          4'h3: next_restored_pc[15:8] = bus_rdata;
          4'h4: next_restored_pc[7:0] = bus_rdata;
          default: next_restored_pc = restored_pc;
        endcase
        if (step == irq_arb_pkg::REC_OPERAND)
        begin
          next_restore_done = 1'b1;
          next_i_mask = restored_ccr[irq_arb_pkg::CCR_I_BIT]; // [R05]
          next_break_active = 1'b0; // [R21]
          next_resume = 1'b1; // [R09]
          next_step = 4'h0;
          next_state = irq_arb_pkg::ST_IDLE;
        end
      end
    endcase
    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == irq_arb_pkg::OFS_BRK_ADDR_HI)
      begin
        next_brk_addr[15:8] = reg_wdata;
      end
      if (reg_addr == irq_arb_pkg::OFS_BRK_ADDR_LO)
      begin
        next_brk_addr[7:0] = reg_wdata;
      end
      if (reg_addr == irq_arb_pkg::OFS_BRK_CTRL)
      begin
        next_brk_en = reg_wdata[irq_arb_pkg::BRK_EN_BIT];
        if (reg_wdata[irq_arb_pkg::BRK_REQ_BIT])
        begin
          next_brk_pending = 1'b1; // [R19]
        end
      end
    end
    // A match in the cycle the pending flag is taken still wins
    if (addr_match)
    begin
      next_breakpoint = 1'b1; // [R18]
      next_brk_pending = 1'b1;
    end
  end

  // Bus cycle for the coming step
  always_comb
  begin
    next_bus_addr = 16'h0000;
    next_bus_wdata = 8'h00;
    next_bus_write = 1'b0;
    next_bus_valid = next_state != irq_arb_pkg::ST_IDLE;
    if (next_state == irq_arb_pkg::ST_ENTRY)
    begin
      // High index register is deliberately not stacked
      unique case (next_step) // [R10] [R11]
        4'h0: next_bus_addr = cpu_pc;
        4'h1: next_bus_addr = next_base_sp;
        4'h2: next_bus_addr = 16'(next_base_sp - 16'h0001);
        4'h3: next_bus_addr = 16'(next_base_sp - 16'h0002);
        4'h4: next_bus_addr = 16'(next_base_sp - 16'h0003);
        4'h5: next_bus_addr = 16'(next_base_sp - 16'h0004);
        irq_arb_pkg::ENT_VEC_HI: next_bus_addr = next_vector_addr;
        irq_arb_pkg::ENT_VEC_LO: next_bus_addr = 16'(next_vector_addr + 16'h0001);
        default: next_bus_addr = {next_vec_hi, next_vec_lo};
      endcase
      unique case (next_step) // [R04]
        4'h1: next_bus_wdata = cpu_pc[7:0];
        4'h2: next_bus_wdata = cpu_pc[15:8];
        4'h3: next_bus_wdata = cpu_x;
        4'h4: next_bus_wdata = cpu_a;
        4'h5: next_bus_wdata = cpu_ccr;
        default: next_bus_wdata = 8'h00;
      endcase
      next_bus_write = (next_step >= 4'h1) && (next_step <= 4'h5);
    end
    else if (next_state == irq_arb_pkg::ST_RECOVER)
    begin
      if (next_step <= 4'h4) // [R12]
      begin
        next_bus_addr = 16'(next_base_sp - 16'h0004 + {12'h000, next_step});
      end
      else if (next_step == irq_arb_pkg::REC_OPCODE)
      begin
        next_bus_addr = next_restored_pc;
      end
      else
      begin
        next_bus_addr = 16'(restored_pc + 16'h0001);
      end
    end
  end

  // Register read data, present only in the cycle after the strobe
  always_comb
  begin
    next_reg_rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        irq_arb_pkg::OFS_STATUS_ONE: next_reg_rdata = {status_flags[5:0], 2'b00}; // [R15]
        irq_arb_pkg::OFS_STATUS_TWO: next_reg_rdata = status_flags[13:6]; // [R16]
        irq_arb_pkg::OFS_STATUS_THREE: next_reg_rdata = status_flags[21:14]; // [R17]
        irq_arb_pkg::OFS_BRK_ADDR_HI: next_reg_rdata = brk_addr[15:8];
        irq_arb_pkg::OFS_BRK_ADDR_LO: next_reg_rdata = brk_addr[7:0];
        irq_arb_pkg::OFS_BRK_CTRL: next_reg_rdata = {brk_en, 1'b0, break_active, 5'h00};
        irq_arb_pkg::OFS_ARB_STATE: next_reg_rdata = {latch_valid, i_mask, 1'b0, latched_id};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= irq_arb_pkg::ST_IDLE;
      step <= 4'h0;
      status_flags <= {irq_arb_pkg::STATUS_RESET[5:0], irq_arb_pkg::STATUS_RESET,
                       irq_arb_pkg::STATUS_RESET}; // [R14]
      latched_id <= 5'h00;
      latch_valid <= 1'b0;
      i_mask <= 1'b1;
      base_sp <= 16'h0000;
      vector_addr <= irq_arb_pkg::VEC_SWI_NORMAL;
      vec_hi <= 8'h00;
      vec_lo <= 8'h00;
      brk_addr <= irq_arb_pkg::BRK_ADDR_RESET;
      brk_en <= 1'b0;
      brk_pending <= 1'b0;
      break_active <= 1'b0;
      resume <= 1'b0;
      load_swi_op <= 1'b0;
      breakpoint_signal <= 1'b0;
      entry_done <= 1'b0;
      restore_done <= 1'b0;
      restored_pc <= 16'h0000;
      restored_a <= 8'h00;
      restored_x <= 8'h00;
      restored_ccr <= 8'h00;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_write <= 1'b0;
      bus_valid <= 1'b0;
      busy <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      status_flags <= 22'(src_req); // [R22] [R14]
      latched_id <= next_latched_id;
      latch_valid <= next_latch_valid;
      i_mask <= next_i_mask;
      base_sp <= next_base_sp;
      vector_addr <= next_vector_addr;
      vec_hi <= next_vec_hi;
      vec_lo <= next_vec_lo;
      brk_addr <= next_brk_addr;
      brk_en <= next_brk_en;
      brk_pending <= next_brk_pending;
      break_active <= next_break_active;
      resume <= next_resume;
      load_swi_op <= next_load_swi_op;
      breakpoint_signal <= next_breakpoint;
      entry_done <= next_entry_done;
      restore_done <= next_restore_done;
      restored_pc <= next_restored_pc;
      restored_a <= next_restored_a;
      restored_x <= next_restored_x;
      restored_ccr <= next_restored_ccr;
      bus_addr <= next_bus_addr;
      bus_wdata <= next_bus_wdata;
      bus_write <= next_bus_write;
      bus_valid <= next_bus_valid;
      busy <= next_state != irq_arb_pkg::ST_IDLE;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  status_follow_a: assert property (!$past(sys_rst) |-> status_flags == $past(src_req)) // [R22]
    else $error("status flags do not follow requests");
  status_low_a: assert property (reg_rd && reg_addr == irq_arb_pkg::OFS_STATUS_ONE
    |=> reg_rdata[1:0] == 2'b00 && reg_rdata[7:2] == $past(status_flags[5:0])) // [R15]
    else $error("first status register layout wrong");
  entry_mask_a: assert property ($rose(busy) && !$past(rti_exec) |-> i_mask) // [R04]
    else $error("mask not set on entry");
  entry_stack_a: assert property (state == irq_arb_pkg::ST_ENTRY && step == 4'h1
    |-> bus_addr == base_sp && bus_write ##4 bus_addr == 16'(base_sp - 16'h0004)
    ##1 bus_addr == vector_addr && !bus_write) // [R11]
    else $error("entry bus sequence wrong");
  hw_wait_a: assert property (state == irq_arb_pkg::ST_IDLE && !instr_done && !resume
    |=> state != irq_arb_pkg::ST_ENTRY) // [R06]
    else $error("entry started mid-instruction");
  mask_block_a: assert property (state == irq_arb_pkg::ST_IDLE && i_mask && !brk_pending
    && !swi_exec && !rti_exec && !addr_match |=> state == irq_arb_pkg::ST_IDLE) // [R07]
    else $error("masked request taken");
  break_vec_a: assert property (load_swi_op |-> vector_addr == ($past(monitor_mode)
    ? irq_arb_pkg::VEC_SWI_MONITOR : irq_arb_pkg::VEC_SWI_NORMAL) && break_active) // [R20]
    else $error("break vector wrong");
  break_end_a: assert property (restore_done |-> !break_active) // [R21]
    else $error("return did not end break");
  latch_hold_a: assert property (latch_valid && !cli_exec && state == irq_arb_pkg::ST_ENTRY
    && step != irq_arb_pkg::ENT_START |=> latched_id == $past(latched_id)) // [R03]
    else $error("latched request displaced");
  recover_seq_a: assert property (state == irq_arb_pkg::ST_RECOVER && step == 4'h0
    |-> bus_addr == 16'(base_sp - 16'h0004) ##4 bus_addr == base_sp) // [R12]
    else $error("return bus sequence wrong");
  match_pulse_a: assert property (addr_match |=> breakpoint_signal && brk_pending) // [R18]
    else $error("break match not flagged");

  entry_c: cover property (entry_done);
  recover_c: cover property (restore_done ##[1:3] state == irq_arb_pkg::ST_ENTRY);
  break_c: cover property (breakpoint_signal ##[1:40] load_swi_op);
  swreq_c: cover property (reg_wr && reg_addr == irq_arb_pkg::OFS_BRK_CTRL
    && reg_wdata[irq_arb_pkg::BRK_REQ_BIT]);
endmodule

// ==== sim/mem_model.sv ====
// Memory model on the far side of the entry and return bus.
// Assumes bus_valid marks every bus cycle that the block makes.
`timescale 1ns/1ps
module mem_model (
  input wire logic mclk,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_valid,
  output logic [7:0] bus_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd;
  // Fixed pattern so vector fetches are predictable
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hA5;
    last_rd = 8'h00;
  end
  // Pushed bytes stay for the return reads
  always @(posedge mclk)
  begin
    if (bus_valid && bus_write)
      mem[bus_addr] <= bus_wdata;
    if (bus_valid && !bus_write)
      last_rd <= bus_rdata;
  end
  // An idle bus shows the inverse of the last read
  assign bus_rdata = bus_valid ? mem[bus_addr] : ~last_rd;
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the interrupt arbiter and break source.
// Assumes mem_model answers the sequencer bus in the same cycle.
`timescale 1ns/1ps
module tb;
  logic mclk, sys_rst, reg_wr, reg_rd, instr_done, swi_exec, rti_exec;
  logic cli_exec, sei_exec, monitor_mode, cpu_addr_valid, bus_write, bus_valid;
  logic busy, i_mask, load_swi_op, breakpoint_signal, entry_done, restore_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cpu_a, cpu_x, cpu_ccr, bus_rdata;
  logic [7:0] bus_wdata, restored_a, restored_x, restored_ccr;
  logic [21:0] src_req, src_en;
  logic [15:0] cpu_addr, cpu_pc, cpu_sp, bus_addr, vector_addr, restored_pc;
  int err_count, num_checks;

  // Design and its memory
  interrupt_arbiter_break_source #(.NUM_SRC(22)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
    .src_en(src_en), .instr_done(instr_done), .swi_exec(swi_exec), .rti_exec(rti_exec),
    .cli_exec(cli_exec), .sei_exec(sei_exec), .monitor_mode(monitor_mode),
    .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid), .cpu_pc(cpu_pc),
    .cpu_sp(cpu_sp), .cpu_a(cpu_a), .cpu_x(cpu_x), .cpu_ccr(cpu_ccr),
    .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_valid(bus_valid), .busy(busy), .i_mask(i_mask),
    .vector_addr(vector_addr), .load_swi_op(load_swi_op),
    .breakpoint_signal(breakpoint_signal), .entry_done(entry_done),
    .restore_done(restore_done), .restored_pc(restored_pc), .restored_a(restored_a),
    .restored_x(restored_x), .restored_ccr(restored_ccr)
  );
  mem_model mem (
    .mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_valid(bus_valid), .bus_rdata(bus_rdata)
  );

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] mem_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      check("idle", {busy, bus_valid}, 2'b00);
    end
  endtask

  task automatic entry_walk(input logic trig, input logic software_interrupt_op, input logic [15:0] vec,
                            input logic brk);
    logic [15:0] ea [1:9];
    logic [7:0] wd [1:6];
    ea = '{cpu_pc, cpu_sp, cpu_sp - 16'h0001, cpu_sp - 16'h0002, cpu_sp - 16'h0003,
           cpu_sp - 16'h0004, vec, vec + 16'h0001, {mem_at(vec), mem_at(vec + 16'h0001)}};
    wd = '{8'h00, cpu_pc[7:0], cpu_pc[15:8], cpu_x, cpu_a, cpu_ccr};
    @(posedge mclk);
    if (trig)
    begin
      instr_done <= 1'b1;
      swi_exec <= software_interrupt_op;
      @(posedge mclk);
      instr_done <= 1'b0;
      swi_exec <= 1'b0;
    end
    #1;
    check("vector", vector_addr, vec);
    check("swi load", load_swi_op, brk);
    for (int k = 1; k < 10; k++)
    begin
      if (k > 1)
      begin
        @(posedge mclk);
        #1;
      end
      check("entry addr", {busy, bus_valid, bus_addr}, {2'b11, ea[k]});
      check("entry dir", bus_write, k > 1 && k < 7);
      if (k > 1 && k < 7)
        check("push data", bus_wdata, wd[k]);
      check("entry mask", i_mask, 1'b1);
    end
    @(posedge mclk);
    #1;
    check("entry done", {busy, entry_done}, 2'b01);
  endtask

  task automatic return_walk();
    logic [15:0] ra [1:7];
    ra = '{cpu_sp - 16'h0004, cpu_sp - 16'h0003, cpu_sp - 16'h0002, cpu_sp - 16'h0001,
           cpu_sp, cpu_pc, cpu_pc + 16'h0001};
    @(posedge mclk);
    rti_exec <= 1'b1;
    @(posedge mclk);
    rti_exec <= 1'b0;
    for (int k = 1; k < 8; k++)
    begin
      #1;
      check("return addr", {bus_write, bus_addr}, {1'b0, ra[k]});
      @(posedge mclk);
    end
    #1;
    check("restore done", {busy, restore_done}, 2'b01);
    check("restored pc", restored_pc, cpu_pc);
    check("restored regs", {restored_a, restored_x, restored_ccr}, {cpu_a, cpu_x, cpu_ccr});
    check("restored mask", i_mask, cpu_ccr[3]);
  endtask

  task automatic s_status();
    logic [7:0] d;
    check("reset outs", {busy, i_mask, vector_addr}, {2'b01, 16'hFFFC});
    reg_read(irq_arb_pkg::OFS_STATUS_ONE, d);
    check("status reset", d, irq_arb_pkg::STATUS_RESET);
    @(posedge mclk);
    src_req <= 22'h2A5C93;
    repeat (2) @(posedge mclk);
    reg_read(irq_arb_pkg::OFS_STATUS_ONE, d);
    check("status one", d, {src_req[5:0], 2'b00});
    reg_write(irq_arb_pkg::OFS_STATUS_TWO, 8'h00);
    reg_read(irq_arb_pkg::OFS_STATUS_TWO, d);
    check("status two", d, src_req[13:6]);
    reg_read(irq_arb_pkg::OFS_STATUS_THREE, d);
    check("status three", d, src_req[21:14]);
    reg_read(8'h3F, d);
    check("unmapped", d, 8'h00);
    @(posedge mclk);
    src_req <= 22'h000000;
    repeat (2) @(posedge mclk);
    reg_read(irq_arb_pkg::OFS_STATUS_THREE, d);
    check("status clear", d, 8'h00);
  endtask

  task automatic s_masked();
    @(posedge mclk);
    src_en <= 22'h000001;
    src_req <= 22'h000001;
    @(posedge mclk);
    instr_done <= 1'b1;
    @(posedge mclk);
    instr_done <= 1'b0;
    quiet(3);
    @(posedge mclk);
    cli_exec <= 1'b1;
    @(posedge mclk);
    cli_exec <= 1'b0;
    src_en <= 22'h000000;
    #1 check("mask clear", i_mask, 1'b0);
    @(posedge mclk);
    instr_done <= 1'b1;
    @(posedge mclk);
    instr_done <= 1'b0;
    src_en <= 22'h000001;
    quiet(4);
  endtask

  task automatic s_pending();
    logic [7:0] d;
    @(posedge mclk);
    src_en <= 22'h000014;
    src_req <= 22'h000014;
    entry_walk(1'b1, 1'b0, irq_arb_pkg::VEC_HW_TOP - 16'h0004, 1'b0);
    reg_read(irq_arb_pkg::OFS_ARB_STATE, d);
    check("arb state", d, 8'h42);
    @(posedge mclk);
    src_req <= 22'h000010;
    return_walk();
    entry_walk(1'b0, 1'b0, irq_arb_pkg::VEC_HW_TOP - 16'h0008, 1'b0);
    @(posedge mclk);
    src_req <= 22'h000000;
    return_walk();
    quiet(2);
  endtask

  task automatic s_break();
    logic [7:0] d;
    @(posedge mclk);
    sei_exec <= 1'b1;
    monitor_mode <= 1'b1;
    entry_walk(1'b1, 1'b1, irq_arb_pkg::VEC_SWI_MONITOR, 1'b0);
    @(posedge mclk);
    sei_exec <= 1'b0;
    monitor_mode <= 1'b0;
    return_walk();
    reg_write(irq_arb_pkg::OFS_BRK_ADDR_HI, 8'h12);
    reg_write(irq_arb_pkg::OFS_BRK_ADDR_LO, 8'h40);
    reg_write(irq_arb_pkg::OFS_BRK_CTRL, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      cpu_addr <= 16'h1241 - 16'(k);
      cpu_addr_valid <= 1'b1;
      @(posedge mclk);
      cpu_addr_valid <= 1'b0;
      #1 check("breakpoint", breakpoint_signal, k);
    end
    entry_walk(1'b1, 1'b0, irq_arb_pkg::VEC_SWI_NORMAL, 1'b1);
    reg_read(irq_arb_pkg::OFS_BRK_CTRL, d);
    check("break active", d, 8'hA0);
    return_walk();
    reg_read(irq_arb_pkg::OFS_BRK_CTRL, d);
    check("break ended", d, 8'h80);
    reg_write(irq_arb_pkg::OFS_BRK_CTRL, 8'h40);
    monitor_mode <= 1'b1;
    entry_walk(1'b1, 1'b0, irq_arb_pkg::VEC_SWI_MONITOR, 1'b1);
    return_walk();
    reg_read(irq_arb_pkg::OFS_BRK_CTRL, d);
    check("soft break end", d, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    err_count = 0;
    num_checks = 0;
    {sys_rst, reg_wr, reg_rd, instr_done, swi_exec, rti_exec} = 6'b100000;
    {cli_exec, sei_exec, monitor_mode, cpu_addr_valid} = 4'b0000;
    {reg_addr, reg_wdata, src_req, src_en, cpu_addr} = '0;
    cpu_pc = 16'h1234;
    cpu_sp = 16'h00F0;
    cpu_a = 8'h5C;
    cpu_x = 8'h3E;
    cpu_ccr = 8'h60;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    s_status();
    s_masked();
    s_pending();
    s_break();
    complete_run();
  end

  // Watchdog
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule
